// [logic/lpmc_low_power_ctrl.sv]
// Function
// - Converter runs in wait, wakes on interrupt
// - Stop halts converter, aborts conversion, resumes
// - Break unit active in wait, idle stop
// - Wait clears mask, stops core clock
// - Stop clears mask; reset sets; clock after recovery
// - Clock generator stays active during wait
// - Stop halts loop; oscillator unless run-in-stop
// - Watchdog runs in wait, timeout resets
// - Stop gates watchdog clock, clears counter
// - Stop honoured only with stop enable
// - Unmasked external interrupt wakes both states
// - Unmasked keypad interrupt wakes both states
// - Supply monitor reset wakes both states
// - Serial unit runs wait, frozen in stop
// - SPI frozen in stop, reset on reset
// - Timers run wait, frozen in stop
// - Timebase runs wait, register access blocked
// - Timebase runs in stop only with oscillator
// - Reset pin or low supply exits stop
// - Irq and keypad edges wake with vectors
// - Recovery counter holds clocks 4096 cycles
// - Short recovery bit gives 32 cycles
`timescale 1ns/1ps
`default_nettype none
module lpmc_low_power_ctrl #(
   parameter int RECOVERY_FULL = 4096,
   parameter int RECOVERY_SHORT = 32
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Core instruction strobes and mask
   input  wire logic               waitExec,
   input  wire logic               stopExec,
   input  wire logic               cpuMaskSet,
   // Configuration bits
   input  wire logic               stopEnable,
   input  wire logic               oscRunInStop,
   input  wire logic               shortStopRecovery,
   input  wire logic               supplyMonitorEnable,
   input  wire logic               supplyMonitorStopEnable,
   input  wire logic               supplyMonitorResetEnable,
   input  wire logic               irqMask,
   input  wire logic               keypadMask,
   input  wire logic               watchdogEnable,
   // Pins and peripheral requests
   input  wire logic               resetPinN,
   input  wire logic               irqPinN,
   input  wire logic               keypadPinN,
   input  wire logic               supplyBelowTrip,
   input  wire logic               watchdogTimeout,
   input  wire logic               periphIrqReq,
   input  wire logic               timebaseRollover,
   // Mode indications
   output lpmc_pkg::lpmc_mode_t    powerMode,
   output logic                    stopActive,
   output logic                    waitActive,
   output logic                    cpuClockEnable,
   output logic                    systemClockEnable,
   output logic                    crystalClockEnable,
   output logic                    pllEnable,
   output logic                    watchdogClockEnable,
   output logic                    watchdogCounterClear,
   output logic                    peripheralFreeze,
   output logic                    converterAbort,
   output logic                    spiReset,
   output logic                    timebaseRun,
   output logic                    timebaseAccessBlock,
   // Core side
   output logic                    cpuMaskForce,
   output logic                    cpuMaskClear,
   output logic                    systemReset,
   output logic                    vectorFetch,
   output logic [15:0]             vectorAddr,
   output lpmc_pkg::lpmc_cause_t   wakeCause
);
   import lpmc_pkg::*;

   localparam logic [11:0] RecFull  = 12'(RECOVERY_FULL - 1);
   localparam logic [11:0] RecShort = 12'(RECOVERY_SHORT - 1);

   lpmc_mode_t         mode_reg;
   lpmc_mode_t         mode_next;
   logic [11:0]        recCnt_reg;
   logic [1:0]         rstPinSync_reg;
   logic [2:0]         irqSync_reg;
   logic [2:0]         keySync_reg;
   logic [1:0]         lowSupSync_reg;
   logic               wakeByReset_reg;
   logic               resetWake;
   logic               irqEdge;
   logic               keyEdge;
   logic               extWake;
   logic               tbWake;
   logic               stopGo;
   logic               monitorLive;

   // Two-flop synchronisers for pins; third stage only for edges
   always_ff @(posedge clk) begin
      if (rst) begin
         rstPinSync_reg <= 2'h3;
         irqSync_reg    <= 3'h7;
         keySync_reg    <= 3'h7;
         lowSupSync_reg <= 2'h0;
      end else begin
         rstPinSync_reg <= {rstPinSync_reg[0], resetPinN};
         irqSync_reg    <= {irqSync_reg[1:0], irqPinN};
         keySync_reg    <= {keySync_reg[1:0], keypadPinN};
         lowSupSync_reg <= {lowSupSync_reg[0], supplyBelowTrip};
      end
   end

   // Wake source decode
   always_comb begin
      monitorLive = supplyMonitorEnable &&
                    (mode_reg != LPMC_STOP || supplyMonitorStopEnable);
      resetWake = !rstPinSync_reg[1] ||
                  (monitorLive && supplyMonitorResetEnable &&
                   lowSupSync_reg[1]) ||
                  (mode_reg != LPMC_STOP && watchdogEnable &&
                   watchdogTimeout);
      irqEdge = irqSync_reg[2] && !irqSync_reg[1] && !irqMask;
      keyEdge = keySync_reg[2] && !keySync_reg[1] && !keypadMask;
      tbWake  = oscRunInStop && timebaseRollover;
      extWake = irqEdge || keyEdge;
      stopGo  = stopExec && stopEnable;
   end

   // Mode sequencing
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         LPMC_RUN: begin
            if (stopGo) begin
               mode_next = LPMC_STOP;
            end else if (waitExec) begin
               mode_next = LPMC_WAIT;
            end
         end
         LPMC_WAIT: begin
            if (resetWake || extWake || periphIrqReq) begin
               mode_next = LPMC_RUN;
            end
         end
         LPMC_STOP: begin
            if (resetWake || extWake) begin
               mode_next = LPMC_RECOVER;
            end else if (tbWake) begin
               mode_next = LPMC_RECOVER;
            end
         end
         LPMC_RECOVER: begin
            if (recCnt_reg == LPMC_REC_ZERO) begin
               mode_next = LPMC_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= LPMC_RUN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Recovery counter, loaded on stop exit
   always_ff @(posedge clk) begin
      if (rst) begin
         recCnt_reg <= LPMC_REC_ZERO;
      end else if (mode_reg == LPMC_STOP && mode_next == LPMC_RECOVER) begin
         recCnt_reg <= shortStopRecovery ? RecShort : RecFull;
      end else if (recCnt_reg != LPMC_REC_ZERO) begin
         recCnt_reg <= recCnt_reg - 12'h001;
      end
   end

   // Wake cause, vector and reset request
   always_ff @(posedge clk) begin
      if (rst) begin
         wakeByReset_reg <= 1'b0;
         wakeCause       <= LPMC_CAUSE_NONE;
         vectorAddr      <= LPMC_VEC_NONE;
         vectorFetch     <= 1'b0;
         systemReset     <= 1'b0;
         cpuMaskForce    <= 1'b0;
         cpuMaskClear    <= 1'b0;
      end else begin
         vectorFetch  <= 1'b0;
         systemReset  <= 1'b0;
         cpuMaskForce <= 1'b0;
         cpuMaskClear <= waitExec && mode_reg == LPMC_RUN ||
                         stopGo && mode_reg == LPMC_RUN;
         if (mode_reg != mode_next && (mode_reg == LPMC_WAIT ||
             mode_reg == LPMC_STOP)) begin
            wakeByReset_reg <= resetWake;
            if (resetWake) begin
               wakeCause  <= LPMC_CAUSE_RESET;
               vectorAddr <= LPMC_VEC_RESET;
            end else if (irqEdge) begin
               wakeCause  <= LPMC_CAUSE_IRQ;
               vectorAddr <= LPMC_VEC_IRQ;
            end else if (keyEdge) begin
               wakeCause  <= LPMC_CAUSE_KEY;
               vectorAddr <= LPMC_VEC_KEY;
            end else if (mode_reg == LPMC_STOP) begin
               wakeCause  <= LPMC_CAUSE_TBASE;
               vectorAddr <= LPMC_VEC_TBASE;
            end else begin
               wakeCause  <= LPMC_CAUSE_PERIPH;
               vectorAddr <= LPMC_VEC_NONE;
            end
         end
         if (mode_next == LPMC_RUN && mode_reg != LPMC_RUN) begin
            vectorFetch  <= 1'b1;
            systemReset  <= mode_reg == LPMC_WAIT ? resetWake
                                                  : wakeByReset_reg;
            cpuMaskForce <= mode_reg == LPMC_WAIT ? resetWake
                                                  : wakeByReset_reg;
         end
      end
   end

   // Per-unit gating outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         powerMode            <= LPMC_RUN;
         stopActive           <= 1'b0;
         waitActive           <= 1'b0;
         cpuClockEnable       <= 1'b1;
         systemClockEnable    <= 1'b1;
         crystalClockEnable   <= 1'b1;
         pllEnable            <= 1'b1;
         watchdogClockEnable  <= 1'b1;
         watchdogCounterClear <= 1'b0;
         peripheralFreeze     <= 1'b0;
         converterAbort       <= 1'b0;
         spiReset             <= 1'b0;
         timebaseRun          <= 1'b1;
         timebaseAccessBlock  <= 1'b0;
      end else begin
         powerMode  <= mode_next;
         stopActive <= mode_next == LPMC_STOP ||
                       mode_next == LPMC_RECOVER;
         waitActive <= mode_next == LPMC_WAIT;
         cpuClockEnable <= mode_next == LPMC_RUN;
         // Clock generator stays up in wait; stop gates it
         systemClockEnable  <= mode_next == LPMC_RUN ||
                               mode_next == LPMC_WAIT;
         crystalClockEnable <= mode_next != LPMC_STOP || oscRunInStop;
         pllEnable          <= mode_next != LPMC_STOP;
         watchdogClockEnable <= mode_next != LPMC_STOP &&
                                mode_next != LPMC_RECOVER;
         watchdogCounterClear <= mode_reg == LPMC_RUN &&
                                 mode_next == LPMC_STOP;
         // Break, serial, SPI and timers hold state in stop
         peripheralFreeze <= mode_next == LPMC_STOP ||
                             mode_next == LPMC_RECOVER;
         converterAbort   <= mode_reg == LPMC_RUN &&
                             mode_next == LPMC_STOP;
         spiReset <= mode_reg == LPMC_STOP && mode_next == LPMC_RECOVER &&
                     resetWake;
         timebaseRun <= mode_next != LPMC_STOP || oscRunInStop;
         timebaseAccessBlock <= mode_next != LPMC_RUN;
      end
   end

   // Assertions
   a_stop_needs_enable: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_RUN && stopExec && !stopEnable
      |=> mode_reg != LPMC_STOP) else $error("stop taken while disabled");
   a_stop_gates_pll: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_STOP |-> !pllEnable)
      else $error("pll running in stop");
   a_osc_stop_low: assert property (@(posedge clk) disable iff (rst)
      $rose(mode_reg == LPMC_STOP) && !oscRunInStop |-> !crystalClockEnable)
      else $error("crystal clock not held low");
   a_wd_clk_stop: assert property (@(posedge clk) disable iff (rst)
      stopActive |-> !watchdogClockEnable)
      else $error("watchdog clocked in stop");
   a_short_recover: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_STOP && mode_next == LPMC_RECOVER && shortStopRecovery
      |=> recCnt_reg == RecShort) else $error("short recovery count wrong");
   a_recover_hold: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_RECOVER && recCnt_reg != LPMC_REC_ZERO
      |=> !systemClockEnable) else $error("clocks early in recovery");
   a_wait_mask_clr: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_RUN && waitExec && !stopGo
      |=> cpuMaskClear ##0 waitActive) else $error("wait entry wrong");
   a_irq_vector: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_WAIT && irqEdge && !resetWake
      |=> vectorAddr == LPMC_VEC_IRQ) else $error("irq vector wrong");
   a_reset_mask: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_WAIT && resetWake |=> cpuMaskForce && systemReset)
      else $error("reset wake did not set mask");
   a_stop_flag: assert property (@(posedge clk) disable iff (rst)
      mode_reg == LPMC_STOP |-> stopActive)
      else $error("stop indication missing");
   // Mode entry, clock, unit gating and wake checks
   a_wait_entry_mode: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_RUN && waitExec && !stopGo |=> powerMode == LPMC_WAIT)
      else $error("wait not entered");
   a_cpu_clk_wait: assert property (
      @(posedge clk) disable iff (rst)
      waitActive |-> !cpuClockEnable) else $error("cpu clock in wait");
   a_pll_in_wait: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_WAIT |-> pllEnable && systemClockEnable)
      else $error("clock generator off in wait");
   a_osc_run_stop: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_STOP && oscRunInStop && $stable(oscRunInStop)
      |-> crystalClockEnable) else $error("oscillator stopped in stop");
   a_wd_clear_pulse: assert property (
      @(posedge clk) disable iff (rst)
      $rose(mode_reg == LPMC_STOP) |-> watchdogCounterClear)
      else $error("watchdog counter not cleared");
   a_abort_conv: assert property (
      @(posedge clk) disable iff (rst)
      $rose(mode_reg == LPMC_STOP) |-> converterAbort)
      else $error("conversion not aborted");
   a_freeze_stop: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_STOP |-> peripheralFreeze)
      else $error("units not frozen in stop");
   a_tb_block: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_WAIT |-> timebaseAccessBlock)
      else $error("timebase open in wait");
   a_tb_stop_off: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_STOP && !oscRunInStop && $stable(oscRunInStop)
      |-> !timebaseRun) else $error("timebase running without oscillator");
   a_spi_reset: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_STOP && resetWake |=> spiReset)
      else $error("spi not reset on reset wake");
   a_key_vector: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_WAIT && keyEdge && !irqEdge && !resetWake
      |=> vectorAddr == LPMC_VEC_KEY) else $error("keypad vector wrong");
   a_recover_fetch: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_RECOVER && recCnt_reg == LPMC_REC_ZERO
      |=> vectorFetch && powerMode == LPMC_RUN) else $error("no run after count");
   a_wait_periph: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_WAIT && periphIrqReq |=> powerMode == LPMC_RUN)
      else $error("peripheral request did not wake");
   a_sup_wait: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == LPMC_WAIT && supplyMonitorEnable &&
      supplyMonitorResetEnable && lowSupSync_reg[1] |=> systemReset)
      else $error("supply reset did not wake");
endmodule
`default_nettype wire

// [logic/lpmc_pkg.sv]
package lpmc_pkg;
   // Power mode encoding (Gray order run, wait, stop, recover; run to stop flips two bits)
   typedef enum logic [1:0] {
      LPMC_RUN     = 2'h0,
      LPMC_WAIT    = 2'h1,
      LPMC_STOP    = 2'h3,
      LPMC_RECOVER = 2'h2
   } lpmc_mode_t;

   // Wake cause reported to the core
   typedef enum logic [2:0] {
      LPMC_CAUSE_NONE  = 3'h0,
      LPMC_CAUSE_RESET = 3'h1,
      LPMC_CAUSE_IRQ   = 3'h2,
      LPMC_CAUSE_KEY   = 3'h3,
      LPMC_CAUSE_TBASE = 3'h4,
      LPMC_CAUSE_PERIPH = 3'h5
   } lpmc_cause_t;

   localparam int          LPMC_REC_W      = 12;
   localparam logic [11:0] LPMC_REC_FULL   = 12'hFFF; // 4096 cycles
   localparam logic [11:0] LPMC_REC_SHORT  = 12'h01F; // 32 cycles
   localparam logic [11:0] LPMC_REC_ZERO   = 12'h000;
   localparam logic [15:0] LPMC_VEC_RESET  = 16'hFFFE;
   localparam logic [15:0] LPMC_VEC_IRQ    = 16'hFFFA;
   localparam logic [15:0] LPMC_VEC_KEY    = 16'hFFE0;
   localparam logic [15:0] LPMC_VEC_TBASE  = 16'hFFDC;
   localparam logic [15:0] LPMC_VEC_NONE   = 16'h0000;
endpackage

// [bench/lpmc_wake_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_wake_model (
   // Clock and command from the bench
   input  wire logic       clk,
   input  wire logic       fire,
   input  wire logic [2:0] sel,
   // Wake sources seen by the block
   output logic            resetPinN,
   output logic            irqPinN,
   output logic            keypadPinN,
   output logic            supplyBelowTrip,
   output logic            watchdogTimeout,
   output logic            periphIrqReq,
   output logic            timebaseRollover
);
   logic [2:0] hold = 3'h0;
   logic       act;
   // Event length counter, restarted by each command
   always @(posedge clk) begin
      if (fire) hold <= 3'h6;
      else if (hold != 3'h0) hold <= hold - 3'h1;
   end
   assign act = (hold != 3'h0);
   // Pins have pull-ups, so a released pin returns high
   assign resetPinN = !(act && sel == 3'h2);
   assign irqPinN = !(act && sel == 3'h0);
   assign keypadPinN = !(act && sel == 3'h1);
   assign supplyBelowTrip = act && sel == 3'h3;
   assign watchdogTimeout = act && sel == 3'h6;
   assign periphIrqReq = act && sel == 3'h5;
   // Rollover is a single-cycle pulse
   assign timebaseRollover = (hold == 3'h6) && sel == 3'h4;
endmodule
`default_nettype wire

// [bench/lpmc_low_power_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_low_power_ctrl_test;
   import lpmc_pkg::*;
   localparam int RF = 64;
   localparam int RS = 8;
   logic clk = 1'b0, rst = 1'b1, waitExec = 1'b0, stopExec = 1'b0;
   logic cpuMaskSet = 1'b0, stopEnable = 1'b0, oscRunInStop = 1'b0;
   logic shortStopRecovery = 1'b0, supplyMonitorEnable = 1'b0;
   logic supplyMonitorStopEnable = 1'b0, supplyMonitorResetEnable = 1'b0;
   logic irqMask = 1'b0, keypadMask = 1'b0, watchdogEnable = 1'b0;
   logic fire = 1'b0, spiSeen = 1'b0, rstSeen = 1'b0;
   logic [2:0] sel = 3'h0;
   logic resetPinN, irqPinN, keypadPinN, supplyBelowTrip, watchdogTimeout;
   logic periphIrqReq, timebaseRollover, stopActive, waitActive;
   logic cpuClockEnable, systemClockEnable, crystalClockEnable, pllEnable;
   logic watchdogClockEnable, watchdogCounterClear, peripheralFreeze;
   logic converterAbort, spiReset, timebaseRun, timebaseAccessBlock;
   logic cpuMaskForce, cpuMaskClear, systemReset, vectorFetch;
   logic [15:0] vectorAddr;
   lpmc_mode_t  powerMode;
   lpmc_cause_t wakeCause;
   int checked = 0, miscompares = 0, cyc = 0;
   lpmc_wake_model i_lpmc_wake_model (.clk, .fire, .sel, .resetPinN,
      .irqPinN, .keypadPinN, .supplyBelowTrip, .watchdogTimeout,
      .periphIrqReq, .timebaseRollover);
   lpmc_low_power_ctrl #(.RECOVERY_FULL(RF), .RECOVERY_SHORT(RS))
      i_lpmc_low_power_ctrl (.clk, .rst, .waitExec, .stopExec, .cpuMaskSet,
      .stopEnable, .oscRunInStop, .shortStopRecovery, .supplyMonitorEnable,
      .supplyMonitorStopEnable, .supplyMonitorResetEnable, .irqMask,
      .keypadMask, .watchdogEnable, .resetPinN, .irqPinN, .keypadPinN,
      .supplyBelowTrip, .watchdogTimeout, .periphIrqReq, .timebaseRollover,
      .powerMode, .stopActive, .waitActive, .cpuClockEnable,
      .systemClockEnable, .crystalClockEnable, .pllEnable,
      .watchdogClockEnable, .watchdogCounterClear, .peripheralFreeze,
      .converterAbort, .spiReset, .timebaseRun, .timebaseAccessBlock,
      .cpuMaskForce, .cpuMaskClear, .systemReset, .vectorFetch, .vectorAddr,
      .wakeCause);
   // Clock, hang limit and sticky pulse catchers
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (spiReset) spiSeen <= 1'b1;
      if (systemReset) rstSeen <= 1'b1;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Pulse one instruction strobe and judge the entry pulses
   task automatic enter(input bit st);
      @(negedge clk);
      stopExec = st;
      waitExec = !st;
      @(posedge clk);
      #1;
      chk("maskClr", 16'(!st || stopEnable), 16'(cpuMaskClear));
      chk("abort", 16'(st && stopEnable), 16'(converterAbort));
      chk("wdClr", 16'(st && stopEnable), 16'(watchdogCounterClear));
      @(negedge clk);
      stopExec = 1'b0;
      waitExec = 1'b0;
   endtask
   // Raise one wake source and follow the block back to run
   task automatic wake(input logic [2:0] s, input logic [15:0] ev,
                       input lpmc_cause_t ec, input int len);
      int rc, n;
      rc = 0;
      n = 0;
      spiSeen = 1'b0;
      rstSeen = 1'b0;
      fire = 1'b1;
      sel = s;
      @(negedge clk);
      fire = 1'b0;
      while (powerMode !== LPMC_RUN && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
         if (powerMode === LPMC_RECOVER) rc++;
      end
      chk("fetch", 16'h0001, 16'(vectorFetch));
      chk("sysClk", 16'h0001, 16'(systemClockEnable));
      chk("cause", 16'(ec), 16'(wakeCause));
      if (ev != 16'h0000) chk("vector", ev, vectorAddr);
      if (len >= 0) chk("recover", 16'(len), 16'(rc));
      // Let the model's event run out before the next command
      repeat (8) @(negedge clk);
   endtask
   task automatic t_reset();
      chk("mode", 16'(LPMC_RUN), 16'(powerMode));
      chk("clocks", 16'h000F, {12'h000, cpuClockEnable, systemClockEnable,
          crystalClockEnable, pllEnable});
      chk("vector", 16'h0000, vectorAddr);
      $display("reset values done");
   endtask
   task automatic t_refused();
      enter(1'b1);
      chk("mode", 16'(LPMC_RUN), 16'(powerMode));
      chk("wdClk", 16'h0001, 16'(watchdogClockEnable));
      $display("stop refused done");
   endtask
   task automatic t_stop_irq();
      stopEnable = 1'b1;
      enter(1'b1);
      chk("mode", 16'(LPMC_STOP), 16'(powerMode));
      chk("stopAct", 16'h0001, 16'(stopActive));
      chk("xtal", 16'h0000, 16'(crystalClockEnable));
      chk("pll", 16'h0000, 16'(pllEnable));
      chk("wdClk", 16'h0000, 16'(watchdogClockEnable));
      chk("sysClk", 16'h0000, 16'(systemClockEnable));
      chk("freeze", 16'h0001, 16'(peripheralFreeze));
      wake(3'h0, LPMC_VEC_IRQ, LPMC_CAUSE_IRQ, RF);
      $display("stop irq wake done");
   endtask
   task automatic t_stop_key();
      oscRunInStop = 1'b1;
      shortStopRecovery = 1'b1;
      irqMask = 1'b1;
      enter(1'b1);
      chk("xtal", 16'h0001, 16'(crystalClockEnable));
      chk("pll", 16'h0000, 16'(pllEnable));
      chk("tbRun", 16'h0001, 16'(timebaseRun));
      fire = 1'b1;
      sel = 3'h0;
      repeat (12) @(negedge clk);
      fire = 1'b0;
      repeat (8) @(negedge clk);
      chk("masked", 16'(LPMC_STOP), 16'(powerMode));
      wake(3'h1, LPMC_VEC_KEY, LPMC_CAUSE_KEY, RS);
      irqMask = 1'b0;
      shortStopRecovery = 1'b0;
      $display("stop keypad short wake done");
   endtask
   task automatic t_stop_misc();
      enter(1'b1);
      wake(3'h4, LPMC_VEC_TBASE, LPMC_CAUSE_TBASE, -1);
      oscRunInStop = 1'b0;
      enter(1'b1);
      wake(3'h2, LPMC_VEC_RESET, LPMC_CAUSE_RESET, RF);
      chk("spiRst", 16'h0001, 16'(spiSeen));
      supplyMonitorEnable = 1'b1;
      supplyMonitorStopEnable = 1'b1;
      supplyMonitorResetEnable = 1'b1;
      enter(1'b1);
      wake(3'h3, LPMC_VEC_RESET, LPMC_CAUSE_RESET, RF);
      $display("stop timebase reset supply done");
   endtask
   task automatic t_wait();
      enter(1'b0);
      chk("mode", 16'(LPMC_WAIT), 16'(powerMode));
      chk("waitAct", 16'h0001, 16'(waitActive));
      chk("cpuClk", 16'h0000, 16'(cpuClockEnable));
      chk("pll", 16'h0001, 16'(pllEnable));
      chk("tbBlock", 16'h0001, 16'(timebaseAccessBlock));
      chk("wdClk", 16'h0001, 16'(watchdogClockEnable));
      wake(3'h5, 16'h0000, LPMC_CAUSE_PERIPH, -1);
      enter(1'b0);
      wake(3'h0, LPMC_VEC_IRQ, LPMC_CAUSE_IRQ, -1);
      watchdogEnable = 1'b1;
      enter(1'b0);
      wake(3'h6, 16'h0000, LPMC_CAUSE_RESET, -1);
      chk("sysRst", 16'h0001, 16'(rstSeen));
      $display("wait wakes done");
   endtask
   // Main sequence
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset();
      t_refused();
      t_stop_irq();
      t_stop_key();
      t_stop_misc();
      t_wait();
      wrap_up();
   end
endmodule
`default_nettype wire
